// [scd_cmd_decoder.sv]
// spacecraft command decoder: tone detector, dual verifier, relays, processor
// Operation
// RL1: one tone is zero, the other one
// RL2: recover bit timing, regenerate bit strobe
// RL3: bit shifts into register and parity together
// RL4: verified command goes to processor or relays
// RL5: real-time word is 32 bits after header
// RL6: word holds unit, subsystem, code, 6-bit parity
// RL7: stored command is two 32-bit halves
// RL8: each half verified by its own parity
// RL9: parity catches 3 errors, odd, bursts
// RL10: prior load code gives memory location
// RL11: sender splits loads above 4096 bits
// RL12: both units run, selected one drives outputs
// RL13: processor sends serial messages per subsystem
// RL14: timing marks share the subsystem lines
// RL15: up to 100 delayed commands stored
// RL16: sequence starts by ground or event
// RL17: compare spacecraft time with stored times
// RL18: memory loads and dumps to telemetry
// RL19: fail-safe sequence held in fixed storage
// RL20: two processors, one active, one spare
// RL21: 128 latching relays, separate set, clear
// RL22: 7-bit relay select plus enable bit
// RL23: parity mismatch discards the command
// RL24: delayed command issued once, then marked
`timescale 1ns/1ns
module scd_cmd_decoder
  import scd_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  // register bus
  input wire logic [AV_AW-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // receiver tones and bit timing
  input wire logic TONE_ZERO,
  input wire logic TONE_ONE,
  input wire logic BIT_TIMING,
  // spacecraft time and onboard event
  input wire logic [TIME_W-1:0] SC_TIME,
  input wire logic SC_TICK,
  input wire logic EVENT_IN,
  // relays and subsystem lines
  output logic [REL_N-1:0] RELAY_STATE,
  output logic [SUB_N-1:0] SUB_DATA,
  output logic [SUB_N-1:0] SUB_CLK,
  // memory dump and processor power
  output scd_entry_s DUMP_ENTRY,
  output logic DUMP_VALID,
  input wire logic DUMP_READY,
  output logic [1:0] PROC_ACTIVE
);
  typedef enum {FR_HUNT, FR_WORD} scd_fr_e;

  logic [4:0] s1_q, s2_q, prev_q;
  logic [TIME_W-1:0] t1_q, t2_q, now_q;
  logic bit_stb, tick_edge, event_edge, tone_ok, bit_val;
  scd_fr_e fr_q;
  logic [HDR_W-1:0] hdr_q;
  logic [CNT_W-1:0] cnt_q;
  logic unit_clr, unit_shift, done_q;
  scd_word_s w_u [2];
  logic ok_u [2];
  scd_word_s w;
  logic sel, good, bad;
  scd_op_e op;
  logic [CTRL_W-1:0] ctrl_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [EVC_W-1:0] good_q, bad_q;
  logic [REL_N-1:0] relay_q;
  logic [LCNT_W-1:0] left_q;
  logic [ADDR_W-1:0] ptr_q;
  logic half_q;
  logic [TIME_W-1:0] tbuf_q;
  logic st_wr;
  scd_entry_s mem_q [MEM_N];
  logic [MEM_N-1:0] memv_q, done_v_q;
  logic rt_pend_q;
  logic [SUB_W-1:0] rt_sub_q;
  logic [CODE_W-1:0] rt_code_q;
  logic arm_q, scan_q, scan_hit, scan_go;
  logic [ADDR_W-1:0] idx_q;
  logic safe_q;
  logic [1:0] safe_idx_q;
  logic req_v, gnt_rt, gnt_safe, gnt_scan;
  logic [SUB_W-1:0] req_sub;
  logic [CODE_W-1:0] req_code;
  logic busy_q;
  logic [CODE_W-1:0] sh_q;
  logic [CNT_W-1:0] nbit_q;
  logic [DIV_W-1:0] div_q;
  logic [SUB_W-1:0] ssub_q;
  logic [SUB_N-1:0] sdat_q, sclk_q;
  logic dump_q, dump_v_q;
  logic [ADDR_W-1:0] didx_q;
  scd_entry_s dent_q;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      s1_q <= '0;
      s2_q <= '0;
      prev_q <= '0;
      t1_q <= '0;
      t2_q <= '0;
    end
    else if (CE)
    begin
      s1_q <= {EVENT_IN, SC_TICK, BIT_TIMING, TONE_ONE, TONE_ZERO};
      s2_q <= s1_q;
      prev_q <= s2_q;
      t1_q <= SC_TIME;
      t2_q <= t1_q;
    end

  // RL2 regenerated bit strobe
  assign bit_stb = CE && s2_q[2] && !prev_q[2];
  assign tick_edge = CE && s2_q[3] && !prev_q[3];
  assign event_edge = CE && s2_q[4] && !prev_q[4];
  // RL1 exactly one tone present
  assign tone_ok = s2_q[0] ^ s2_q[1];
  assign bit_val = s2_q[1];

  // ----------------------------------------
  // framing: header hunt, then one word
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      fr_q <= FR_HUNT;
      hdr_q <= '0;
      cnt_q <= '0;
      done_q <= 1'b0;
    end
    else if (CE)
    begin
      done_q <= 1'b0;
      if (bit_stb)
        case (fr_q)
          FR_HUNT:
          begin
            hdr_q <= tone_ok ? {hdr_q[HDR_W-2:0], bit_val} : '0;
            cnt_q <= '0;
            if (tone_ok && {hdr_q[HDR_W-2:0], bit_val} == HDR_PATTERN)
              fr_q <= FR_WORD;
          end
          FR_WORD:
          begin
            hdr_q <= '0;
            cnt_q <= cnt_q + 1'b1;
            // RL1 a lost tone abandons the word
            if (!tone_ok)
              fr_q <= FR_HUNT;
            // RL5 word ends after 32 bits
            else if (cnt_q == CNT_W'(WORD_W - 1))
            begin
              fr_q <= FR_HUNT;
              done_q <= 1'b1;
            end
          end
          default: fr_q <= FR_HUNT;
        endcase
    end

  assign unit_clr = bit_stb && fr_q == FR_HUNT;
  assign unit_shift = bit_stb && fr_q == FR_WORD && tone_ok;

  // ----------------------------------------
  // two verifier units, both always running
  // ----------------------------------------
  for (genvar u = 0; u < 2; u++)
  begin : g_unit
    scd_dv_unit u_dv (
      .clk(CLK),
      .rst_n(RESET_N),
      .ce(CE),
      .clr(unit_clr),
      .shift(unit_shift),
      .par_phase(cnt_q < CNT_W'(PAR_SPAN)),
      .bit_in(bit_val),
      .word(w_u[u]),
      .ok(ok_u[u])
    );
  end

  // RL12 selected unit alone drives the result
  assign sel = w_u[0].unit;
  assign w = w_u[sel];
  // RL23 mismatch or disabled unit discards
  assign good = done_q && ok_u[sel] && ctrl_q[sel];
  assign bad = done_q && !good;
  // RL6 code field carries processor operation
  assign op = scd_op_e'(w.code[CODE_W-1 -: OP_W]);

  // ----------------------------------------
  // register bus, one wait state
  // ----------------------------------------
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;
  assign AVS_READDATA = rdata_q;

  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      ack_q <= 1'b0;
      rdata_q <= '0;
      ctrl_q <= CTRL_RST;
    end
    else if (CE)
    begin
      ack_q <= (AVS_READ || AVS_WRITE) && !ack_q;
      if (AVS_READ && !ack_q)
      begin
        rdata_q <= '0;
        if (AVS_ADDRESS[AV_AW-1 -: 2] == REG_RELAY[AV_AW-1 -: 2])
          rdata_q <= relay_q[{AVS_ADDRESS[3:2], 5'h00} +: 32];
        else
          case (AVS_ADDRESS)
            REG_CTRL: rdata_q[CTRL_W-1:0] <= ctrl_q;
            REG_STAT: rdata_q[6:0] <= {fr_q == FR_WORD, busy_q, dump_q, left_q != '0, safe_q, scan_q, arm_q};
            REG_GOOD: rdata_q[EVC_W-1:0] <= good_q;
            REG_BAD: rdata_q[EVC_W-1:0] <= bad_q;
            default: rdata_q <= '0;
          endcase
      end
      if (AVS_WRITE && ack_q && AVS_ADDRESS == REG_CTRL)
        ctrl_q <= AVS_WRITEDATA[CTRL_W-1:0];
    end

  // RL20 one processor powered, other spare
  assign PROC_ACTIVE = ctrl_q[CTRL_PSEL] ? 2'h2 : 2'h1;

  // ----------------------------------------
  // routing: relays, processor, stored halves
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      good_q <= '0;
      bad_q <= '0;
      relay_q <= '0;
      left_q <= '0;
      ptr_q <= '0;
      half_q <= 1'b0;
      tbuf_q <= '0;
    end
    else if (CE)
    begin
      if (good)
        good_q <= good_q + 1'b1;
      if (bad)
        bad_q <= bad_q + 1'b1;
      // RL7 load mode takes words in pairs
      if (good && left_q != '0)
      begin
        half_q <= !half_q;
        if (!half_q)
          tbuf_q <= {w.sub, w.code[TIME_W-SUB_W-1:0]};
        else
        begin
          left_q <= left_q - 1'b1;
          ptr_q <= ptr_q + 1'b1;
        end
      end
      // RL8 a bad half drops the whole pair
      else if (bad && left_q != '0)
        half_q <= 1'b0;
      // RL4 route by subsystem field
      else if (good && w.sub == SUB_RELAY)
        // RL21 RL22 latch one relay on or off
        relay_q[w.code[REL_W:1]] <= w.code[0];
      else if (good && w.sub == SUB_PROC && op == OP_LOAD)
      begin
        // RL10 load address from this code field
        ptr_q <= w.code[LCNT_W +: ADDR_W];
        left_q <= w.code[LCNT_W-1:0];
        half_q <= 1'b0;
      end
    end

  assign RELAY_STATE = relay_q;

  // ----------------------------------------
  // delayed command memory
  // ----------------------------------------
  // RL15 entries beyond the last slot are dropped
  assign st_wr = good && left_q != '0 && half_q && ptr_q < ADDR_W'(MEM_N);

  always_ff @(posedge CLK)
    if (CE && st_wr)
      mem_q[ptr_q] <= '{etime: tbuf_q, sub: w.sub, code: w.code, done: 1'b0};

  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      memv_q <= '0;
      done_v_q <= '0;
    end
    else if (CE)
    begin
      if (st_wr)
      begin
        memv_q[ptr_q] <= 1'b1;
        done_v_q[ptr_q] <= 1'b0;
      end
      // RL24 mark issued entry
      if (gnt_scan)
        done_v_q[idx_q] <= 1'b1;
    end

  // ----------------------------------------
  // sequence control and time scan
  // ----------------------------------------
  // RL17 stored time equals spacecraft time
  assign scan_hit = scan_q && memv_q[idx_q] && !done_v_q[idx_q] && mem_q[idx_q].etime == now_q;
  // RL16 ground start or onboard event
  assign scan_go = (good && left_q == '0 && w.sub == SUB_PROC && op == OP_START) || event_edge;

  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      now_q <= '0;
      arm_q <= 1'b0;
      scan_q <= 1'b0;
      idx_q <= '0;
      safe_q <= 1'b0;
      safe_idx_q <= '0;
      rt_pend_q <= 1'b0;
      rt_sub_q <= '0;
      rt_code_q <= '0;
    end
    else if (CE)
    begin
      if (tick_edge)
        now_q <= t2_q;
      if (scan_go || (tick_edge && arm_q))
      begin
        arm_q <= 1'b1;
        scan_q <= 1'b1;
        idx_q <= '0;
      end
      else if (good && left_q == '0 && w.sub == SUB_PROC && op == OP_STOP)
      begin
        arm_q <= 1'b0;
        scan_q <= 1'b0;
      end
      // a hit stalls the scan until the sender is free
      else if (scan_q && (!scan_hit || gnt_scan))
      begin
        idx_q <= idx_q + 1'b1;
        if (idx_q == ADDR_W'(MEM_N - 1))
          scan_q <= 1'b0;
      end
      // RL19 fail-safe sequence from fixed table
      if (good && left_q == '0 && w.sub == SUB_PROC && op == OP_SAFE)
      begin
        safe_q <= 1'b1;
        safe_idx_q <= '0;
      end
      else if (gnt_safe)
      begin
        safe_idx_q <= safe_idx_q + 1'b1;
        if (safe_idx_q == 2'(SAFE_N - 1))
          safe_q <= 1'b0;
      end
      // RL13 real-time nondiscrete message queued
      if (good && left_q == '0 && w.sub != SUB_RELAY && w.sub != SUB_PROC && !rt_pend_q)
      begin
        rt_pend_q <= 1'b1;
        rt_sub_q <= w.sub;
        rt_code_q <= w.code;
      end
      else if (gnt_rt)
        rt_pend_q <= 1'b0;
    end

  // ----------------------------------------
  // serial sender arbitration
  // ----------------------------------------
  always_comb
  begin
    req_v = 1'b0;
    req_sub = '0;
    req_code = '0;
    gnt_rt = 1'b0;
    gnt_safe = 1'b0;
    gnt_scan = 1'b0;
    if (rt_pend_q)
    begin
      req_v = 1'b1;
      {req_sub, req_code} = {rt_sub_q, rt_code_q};
      gnt_rt = !busy_q;
    end
    else if (safe_q)
    begin
      req_v = 1'b1;
      {req_sub, req_code} = SAFE_ROM[safe_idx_q];
      gnt_safe = !busy_q;
    end
    else if (scan_hit)
    begin
      req_v = 1'b1;
      {req_sub, req_code} = {mem_q[idx_q].sub, mem_q[idx_q].code};
      gnt_scan = !busy_q;
    end
  end

  // RL13 code shifted out on target line
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      busy_q <= 1'b0;
      sh_q <= '0;
      nbit_q <= '0;
      div_q <= '0;
      ssub_q <= '0;
      sdat_q <= '0;
      sclk_q <= '0;
    end
    else if (CE)
    begin
      sdat_q <= '0;
      sclk_q <= '0;
      if (!busy_q && req_v)
      begin
        busy_q <= 1'b1;
        sh_q <= req_code;
        ssub_q <= req_sub;
        nbit_q <= '0;
        div_q <= '0;
      end
      else if (busy_q)
      begin
        sdat_q[ssub_q] <= sh_q[CODE_W-1];
        sclk_q[ssub_q] <= div_q >= DIV_W'(SER_DIV / 2);
        div_q <= div_q + 1'b1;
        if (div_q == DIV_W'(SER_DIV - 1))
        begin
          sh_q <= {sh_q[CODE_W-2:0], 1'b0};
          nbit_q <= nbit_q + 1'b1;
          if (nbit_q == CNT_W'(CODE_W - 1))
            busy_q <= 1'b0;
        end
      end
      // RL14 timing mark: data high, clock idle
      else if (tick_edge)
        sdat_q <= '1;
    end

  assign SUB_DATA = sdat_q;
  assign SUB_CLK = sclk_q;

  // ----------------------------------------
  // memory dump to telemetry
  // ----------------------------------------
  // RL18 dump every slot in order
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      dump_q <= 1'b0;
      dump_v_q <= 1'b0;
      didx_q <= '0;
      dent_q <= '0;
    end
    else if (CE)
    begin
      if (good && left_q == '0 && w.sub == SUB_PROC && op == OP_DUMP && !dump_q)
      begin
        dump_q <= 1'b1;
        didx_q <= '0;
      end
      else if (dump_q && !dump_v_q)
      begin
        dent_q <= memv_q[didx_q] ? mem_q[didx_q] : '0;
        dent_q.done <= done_v_q[didx_q];
        dump_v_q <= 1'b1;
      end
      else if (dump_v_q && DUMP_READY)
      begin
        dump_v_q <= 1'b0;
        didx_q <= didx_q + 1'b1;
        if (didx_q == ADDR_W'(MEM_N - 1))
          dump_q <= 1'b0;
      end
    end

  assign DUMP_ENTRY = dent_q;
  assign DUMP_VALID = dump_v_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  tone_loss_a: assert property (CE && bit_stb && fr_q == FR_WORD && !tone_ok |=> fr_q == FR_HUNT) // RL1
    else $error("word kept after tone loss");
  strobe_once_a: assert property (bit_stb |=> !bit_stb) // RL2
    else $error("bit strobe longer than one cycle");
  relay_route_a: assert property (CE && good && left_q == '0 && w.sub == SUB_RELAY // RL4
    |=> relay_q[$past(w.code[REL_W:1])] == $past(w.code[0]))
    else $error("relay not latched by command");
  discard_bad_a: assert property (CE && bad && !st_wr |=> relay_q == $past(relay_q) && good_q == $past(good_q)) // RL23
    else $error("bad command had an effect");
  load_addr_a: assert property (CE && good && left_q == '0 && w.sub == SUB_PROC && op == OP_LOAD // RL10
    |=> ptr_q == $past(w.code[LCNT_W +: ADDR_W]))
    else $error("load address not taken");
  once_only_a: assert property (CE && gnt_scan |=> done_v_q[$past(idx_q)] && !scan_hit || idx_q != $past(idx_q)) // RL24
    else $error("issued entry not marked");
  time_match_a: assert property (gnt_scan |-> mem_q[idx_q].etime == now_q && !done_v_q[idx_q]) // RL17
    else $error("issued at wrong time");
  send_busy_a: assert property (CE && !busy_q && req_v |=> busy_q [*8]) // RL13
    else $error("sender dropped a message");
  one_proc_a: assert property ($onehot(PROC_ACTIVE)) // RL20
    else $error("processor power not exclusive");
  store_cap_a: assert property (st_wr |-> ptr_q < ADDR_W'(MEM_N)) // RL15
    else $error("store beyond capacity");

  word_done_c: cover property (good && w.sub == SUB_RELAY);
  pair_stored_c: cover property (st_wr);
  scan_issue_c: cover property (gnt_scan);
  dump_beat_c: cover property (dump_v_q && DUMP_READY);
endmodule // scd_cmd_decoder

// [scd_pkg.sv]
// shared constants and types of the spacecraft command decoder
package scd_pkg;
  // ----------------------------------------
  // command word and parity
  // ----------------------------------------
  localparam int WORD_W = 32;
  localparam int PAR_W = 6;
  localparam int HDR_W = 8;
  localparam int SUB_W = 4;
  localparam int CODE_W = 21;
  localparam int TIME_W = 24;
  localparam int CNT_W = 5;
  localparam int PAR_SPAN = WORD_W - PAR_W;
  localparam logic [HDR_W-1:0] HDR_PATTERN = 8'hE2;
  // x^6+x^5+x^3+x^2+x+1: the (x+1) factor catches every odd error count
  localparam logic [PAR_W-1:0] PAR_POLY = 6'h2F;
  localparam logic [PAR_W-1:0] PAR_INIT = 6'h00;
  // ----------------------------------------
  // routing, relays, processor
  // ----------------------------------------
  localparam logic [SUB_W-1:0] SUB_RELAY = 4'h0;
  localparam logic [SUB_W-1:0] SUB_PROC = 4'h1;
  localparam int SUB_N = 16;
  localparam int REL_N = 128;
  localparam int REL_W = 7;
  localparam int OP_W = 3;
  localparam int ADDR_W = 7;
  localparam int LCNT_W = 11;
  localparam int MEM_N = 100;
  localparam int SER_DIV = 16;
  localparam int DIV_W = 4;
  localparam int SAFE_N = 4;
  localparam logic [SUB_W+CODE_W-1:0] SAFE_ROM [SAFE_N] = '{25'h0400001, 25'h0600002, 25'h0800003, 25'h0A00004};
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int AV_AW = 6;
  localparam logic [AV_AW-1:0] REG_CTRL = 6'h00;
  localparam logic [AV_AW-1:0] REG_STAT = 6'h04;
  localparam logic [AV_AW-1:0] REG_GOOD = 6'h08;
  localparam logic [AV_AW-1:0] REG_BAD = 6'h0C;
  localparam logic [AV_AW-1:0] REG_RELAY = 6'h10;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h3;
  localparam int CTRL_PSEL = 2;
  localparam int EVC_W = 16;

  typedef enum logic [OP_W-1:0] {OP_NONE, OP_LOAD, OP_START, OP_STOP, OP_DUMP, OP_SAFE} scd_op_e;

  typedef struct packed {
    logic unit;
    logic [SUB_W-1:0] sub;
    logic [CODE_W-1:0] code;
    logic [PAR_W-1:0] par;
  } scd_word_s;

  typedef struct packed {
    logic [TIME_W-1:0] etime;
    logic [SUB_W-1:0] sub;
    logic [CODE_W-1:0] code;
    logic done;
  } scd_entry_s;
endpackage

// [scd_dv_unit.sv]
// one detect/decode/verify unit: decode shift register and parity generator
`timescale 1ns/1ns
module scd_dv_unit
  import scd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // bit stream
  input wire logic clr,
  input wire logic shift,
  input wire logic par_phase,
  input wire logic bit_in,
  // result
  output scd_word_s word,
  output logic ok
);
  logic [WORD_W-1:0] word_q;
  logic [PAR_W-1:0] crc_q;
  logic fb;

  assign fb = bit_in ^ crc_q[PAR_W-1];

  // ----------------------------------------
  // shift and parity
  // ----------------------------------------
  // RL3 same-cycle shift and parity
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      word_q <= '0;
      crc_q <= PAR_INIT;
    end
    else if (ce)
    begin
      if (clr)
      begin
        word_q <= '0;
        crc_q <= PAR_INIT;
      end
      else if (shift)
      begin
        word_q <= {word_q[WORD_W-2:0], bit_in};
        // RL9 six-bit polynomial division
        if (par_phase)
          crc_q <= {crc_q[PAR_W-2:0], 1'b0} ^ (fb ? PAR_POLY : PAR_INIT);
      end
    end

  assign word = scd_word_s'(word_q);
  assign ok = (crc_q == word_q[PAR_W-1:0]);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  shift_in_a: assert property (@(posedge clk) disable iff (!rst_n) // RL3
    ce && shift && !clr |=> word_q[0] == $past(bit_in))
    else $error("decode register missed a bit");
  par_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RL9
    ce && shift && !clr && !par_phase |=> crc_q == $past(crc_q))
    else $error("parity moved on a parity-field bit");
endmodule // scd_dv_unit

// [scd_ground_model.sv]
// ground sender model: command tones with amplitude-borne bit timing
`timescale 1ns/1ns
module scd_ground_model
  import scd_pkg::*;
(
  // receiver tone outputs
  output logic tone_zero,
  output logic tone_one,
  output logic bit_timing
);
  // ----------------------------------------
  // idle link: no tone, timing stands still
  // ----------------------------------------
  initial
  begin
    tone_zero = 1'b0;
    tone_one = 1'b0;
    bit_timing = 1'b0;
  end

  function automatic logic [PAR_W-1:0] crc(input logic [PAR_SPAN-1:0] b);
    logic [PAR_W-1:0] c;
    c = PAR_INIT;
    for (int i = PAR_SPAN - 1; i >= 0; i--)
      c = {c[PAR_W-2:0], 1'b0} ^ ((c[PAR_W-1] ^ b[i]) ? PAR_POLY : 6'h00);
    return c;
  endfunction

  task automatic tx_bit(input logic b);
    tone_one <= b;
    tone_zero <= !b;
    #32;
    bit_timing <= 1'b1;
    #32;
    bit_timing <= 1'b0;
  endtask

  task automatic send(input logic u, input logic [SUB_W-1:0] s, input logic [CODE_W-1:0] c,
                      input logic [31:0] flip);
    logic [31:0] v;
    v = {u, s, c, crc({u, s, c})} ^ flip;
    for (int i = HDR_W - 1; i >= 0; i--)
      tx_bit(HDR_PATTERN[i]);
    for (int i = 31; i >= 0; i--)
      tx_bit(v[i]);
    // released link: both tones absent
    tone_one <= 1'b0;
    tone_zero <= 1'b0;
  endtask
endmodule // scd_ground_model

// [tb.sv]
// testbench: command decoder driven by the ground sender model
`timescale 1ns/1ns
module tb;
  import scd_pkg::*;
  logic clk = 0, rst_n = 0, sc_tick = 0, ev_in = 0, dump_rdy = 0, av_rd = 0, av_wr = 0;
  logic [AV_AW-1:0] av_a = '0;
  logic [31:0] av_wd = '0, av_q, q;
  logic av_wait, tz, t1, bt, dump_v;
  logic [TIME_W-1:0] sc_time = '0;
  logic [REL_N-1:0] rel;
  logic [SUB_N-1:0] sub_d, sub_c;
  logic [1:0] pact;
  scd_entry_s dump_e;
  int mismatches = 0, n_compared = 0, nclk3 = 0, nmark = 0;

  always #4 clk = !clk;
  always @(posedge sub_c[3]) nclk3++;
  // timing mark: every subsystem data line high together
  always @(posedge clk) if (sub_d === '1) nmark++;

  scd_ground_model i_gnd (.tone_zero(tz), .tone_one(t1), .bit_timing(bt));
  scd_cmd_decoder i_dut (.CLK(clk), .RESET_N(rst_n), .CE(1'b1), .AVS_ADDRESS(av_a), .AVS_READ(av_rd),
    .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd), .AVS_READDATA(av_q), .AVS_WAITREQUEST(av_wait),
    .TONE_ZERO(tz), .TONE_ONE(t1), .BIT_TIMING(bt), .SC_TIME(sc_time), .SC_TICK(sc_tick), .EVENT_IN(ev_in),
    .RELAY_STATE(rel), .SUB_DATA(sub_d), .SUB_CLK(sub_c), .DUMP_ENTRY(dump_e), .DUMP_VALID(dump_v),
    .DUMP_READY(dump_rdy), .PROC_ACTIVE(pact));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [127:0] s, input logic [127:0] e);
    n_compared++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // request held until the rising edge that sees waitrequest low
  task automatic av(input logic w, input logic [AV_AW-1:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    av_a <= a;
    av_wd <= d;
    av_wr <= w;
    av_rd <= !w;
    @(posedge clk);
    while (av_wait !== 1'b0)
      @(posedge clk);
    r = av_q;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic snd(input logic u, input logic [SUB_W-1:0] s, input logic [CODE_W-1:0] c, input logic [31:0] f);
    i_gnd.send(u, s, c, f);
    wt(12);
  endtask

  task automatic rx(input int s, output logic [CODE_W-1:0] m);
    for (int i = CODE_W - 1; i >= 0; i--)
    begin
      @(posedge sub_c[s]);
      m[i] = sub_d[s];
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("proc_active", pact, 2'b01);
    av(0, REG_CTRL, 0, q);
    chk("ctrl", q, 32'h3);
    av(1, 6'h20, 32'hFFFFFFFF, q);
    av(0, 6'h20, 0, q);
    chk("unmapped", q, 0);
  endtask

  task automatic t_relay();
    snd(0, SUB_RELAY, {13'h0, 7'd127, 1'b1}, 0);
    chk("relay127", rel[127], 1);
    snd(0, SUB_RELAY, {13'h0, 7'd0, 1'b1}, 0);
    av(0, REG_RELAY + 6'h0C, 0, q);
    chk("relay_reg", q[31], 1);
    snd(0, SUB_RELAY, {13'h0, 7'd127, 1'b0}, 0);
    chk("relays", rel, 128'h1);
  endtask

  task automatic t_parity();
    logic [31:0] g0, b0;
    av(0, REG_GOOD, 0, g0);
    av(0, REG_BAD, 0, b0);
    snd(0, SUB_RELAY, {13'h0, 7'd5, 1'b1}, 32'h1);
    snd(0, SUB_RELAY, {13'h0, 7'd5, 1'b1}, 32'h7C00);
    snd(0, SUB_RELAY, {13'h0, 7'd5, 1'b1}, 32'h80000041);
    chk("relays_bad", rel, 128'h1);
    av(0, REG_BAD, 0, q);
    chk("bad_cnt", q[EVC_W-1:0], b0[EVC_W-1:0] + 16'h3);
    av(0, REG_GOOD, 0, q);
    chk("good_cnt", q, g0);
  endtask

  task automatic t_units();
    av(1, REG_CTRL, 32'h2, q);
    snd(0, SUB_RELAY, {13'h0, 7'd9, 1'b1}, 0);
    chk("unit0_off", rel[9], 0);
    snd(1, SUB_RELAY, {13'h0, 7'd9, 1'b1}, 0);
    chk("unit1_on", rel[9], 1);
    av(1, REG_CTRL, 32'h7, q);
    wt(2);
    chk("proc_b", pact, 2'b10);
    av(1, REG_CTRL, 32'h3, q);
    wt(2);
    chk("proc_a", pact, 2'b01);
  endtask

  task automatic t_msg();
    logic [CODE_W-1:0] m;
    fork
      i_gnd.send(0, 4'h2, 21'h15A5C3, 0);
      rx(2, m);
    join
    chk("rt_msg", m, 21'h15A5C3);
    fork
      i_gnd.send(0, SUB_PROC, {3'h5, 18'h0}, 0);
      rx(2, m);
    join
    chk("safe_msg", m, SAFE_ROM[0][CODE_W-1:0]);
    // let the rest of the fail-safe table drain off the lines
    wt(1200);
  endtask

  task automatic t_stored();
    logic [CODE_W-1:0] m;
    logic [TIME_W-1:0] tm;
    scd_entry_s e0;
    int n, c0, m0;
    tm = 24'h123456;
    n = 0;
    snd(0, SUB_PROC, {3'h1, 7'd0, 11'd1}, 0);
    snd(0, tm[23:20], {1'b0, tm[19:0]}, 0);
    snd(0, 4'h3, 21'h0ABCDE, 0);
    ev_in <= 1'b1;
    wt(8);
    ev_in <= 1'b0;
    sc_time <= tm;
    wt(8);
    sc_tick <= 1'b1;
    fork
      rx(3, m);
      begin wt(8); sc_tick <= 1'b0; end
    join
    chk("delayed", m, 21'h0ABCDE);
    wt(8);
    c0 = nclk3;
    m0 = nmark;
    sc_tick <= 1'b1;
    wt(8);
    sc_tick <= 1'b0;
    wt(400);
    chk("once", nclk3, c0);
    chk("mark", nmark, m0 + 1);
    snd(0, SUB_PROC, {3'h4, 18'h0}, 0);
    // ready toggles so the dump sees stalls
    repeat (800)
    begin
      @(negedge clk);
      if (dump_v === 1'b1 && dump_rdy === 1'b1)
      begin
        if (n == 0)
          e0 = dump_e;
        n++;
      end
      @(posedge clk);
      dump_rdy <= !dump_rdy;
    end
    chk("dump_n", n, MEM_N);
    chk("dump_0", e0, {tm, 4'h3, 21'h0ABCDE, 1'b1});
    snd(0, SUB_PROC, {3'h3, 18'h0}, 0);
    av(0, REG_STAT, 0, q);
    chk("stopped", q[0], 0);
    snd(0, SUB_PROC, {3'h2, 18'h0}, 0);
    av(0, REG_STAT, 0, q);
    chk("started", q[0], 1);
  endtask

  task automatic summarize();
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    wt(16);
    rst_n <= 1'b1;
    t_reset();
    t_relay();
    t_parity();
    t_units();
    t_msg();
    t_stored();
    summarize();
  end

  initial
  begin
    #600000;
    mismatches++;
    summarize();
  end
endmodule // tb
